// file: core/serial_rx_pkg.sv
// package: constants and types for the decimal-capable serial receiver
package serial_rx_pkg;
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned MS_PER_S = 1000;
  localparam int unsigned TICK_MS = 1;
  localparam int unsigned CYC_PER_MS = CLK_HZ / MS_PER_S * TICK_MS;
  localparam logic [15:0] BAUD_RST = 16'h2580;
  localparam logic [15:0] TMO_RST = 16'h2710;
  localparam logic INV_RST = 1'b1;
  localparam int unsigned DATA_BITS = 8;
  localparam logic [7:0] ASCII_ZERO = 8'h30;
  localparam logic [7:0] ASCII_NINE = 8'h39;
  localparam logic [15:0] TEN = 16'h000a;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_WAIT = 3'b001,
    ST_START = 3'b010,
    ST_DATA = 3'b011,
    ST_STOP = 3'b100
  } rx_state_e;

  typedef struct packed {
    logic [15:0] baud;
    logic [15:0] timeout_ms;
    logic timeout_en;
    logic invert;
    logic [3:0] pin_sel;
  } rx_cfg_s;

  typedef struct packed {
    logic done;
    logic timed_out;
    logic [15:0] value;
  } rx_result_s;
endpackage

// file: core/serial_rx_dec.sv
// module: software-style asynchronous 8n1 receiver with optional decimal conversion
//
// Summary of operation
// - frame is start, eight data, stop
// - selected pin made input at start
// - timeout counts milliseconds, then reports timeout
// - timeout 0..65535 ms, start wait only
// - default timeout ten thousand milliseconds
// - timeout disabled means wait forever
// - polarity: 1 inverted, 0 true; default inverted
// - baud 0..65535, default 9600
// - standard rates 300 to 19200 work
// - raw mode stores character code unchanged
// - items filled in sequence, one each
// - decimal mode discards until first digit
// - accumulate value times ten plus digit
// - finish only after digit then non-digit
// - decimal result 16 bits, wraps silently
`timescale 1ns/1ps
module serial_rx_dec
  import serial_rx_pkg::*;
#(
  parameter int unsigned PINS = 16,
  parameter int unsigned CLK_FREQ = CLK_HZ
) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic [PINS-1:0] pins_i,
  input wire rx_cfg_s cfg_i,
  input wire logic item_start_i,
  input wire logic item_dec_i,
  output logic [PINS-1:0] pin_oe_o,
  output logic busy_o,
  output rx_result_s result_o
);
  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  // whole state in one struct
  typedef struct packed {
    rx_state_e st;
    logic busy;
    logic [31:0] cnt;
    logic [15:0] ms;
    logic [31:0] ms_cnt;
    logic [2:0] bit_idx;
    logic [7:0] shreg;
    logic dec;
    logic seen_digit;
    logic [15:0] acc;
    logic [PINS-1:0] oe;
    rx_result_s res;
  } state_s;

  state_s s_r;
  state_s s_nxt;
  logic line;
  logic [31:0] bit_cyc;
  logic [7:0] ch;

  // ------------------------------------------------------------
  // decode helpers
  // ------------------------------------------------------------
  function automatic logic is_digit(input logic [7:0] c);
    is_digit = (c >= ASCII_ZERO) && (c <= ASCII_NINE);
  endfunction

  // ------------------------------------------------------------
  // input selection and bit timing
  // ------------------------------------------------------------
  // line polarity: idle mark seen as 1 after correction
  assign line = pins_i[cfg_i.pin_sel] ^ cfg_i.invert;
  // a zero baud is treated as the slowest rate of one bit per second
  assign bit_cyc = (cfg_i.baud == 16'h0000) ? CLK_FREQ : CLK_FREQ / 32'(cfg_i.baud);
  assign ch = {line, s_r.shreg[7:1]};

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    s_nxt.res.done = 1'b0;
    case (s_r.st)
      ST_IDLE: begin
        if (item_start_i) begin
          s_nxt.oe = '0;
          s_nxt.dec = item_dec_i;
          s_nxt.seen_digit = 1'b0;
          s_nxt.acc = '0;
          s_nxt.ms = '0;
          s_nxt.ms_cnt = '0;
          s_nxt.st = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (!line) begin
          s_nxt.cnt = '0;
          s_nxt.st = ST_START;
        end else if (cfg_i.timeout_en) begin
          if (s_r.ms_cnt == CYC_PER_MS - 1) begin
            s_nxt.ms_cnt = '0;
            s_nxt.ms = s_r.ms + 16'h0001;
          end else begin
            s_nxt.ms_cnt = s_r.ms_cnt + 32'h1;
          end
          if (s_r.ms >= cfg_i.timeout_ms) begin
            s_nxt.res.done = 1'b1;
            s_nxt.res.timed_out = 1'b1;
            s_nxt.st = ST_IDLE;
          end
        end
      end
      ST_START: begin
        if (s_r.cnt == (bit_cyc >> 1)) begin
          s_nxt.cnt = '0;
          s_nxt.bit_idx = '0;
          s_nxt.st = line ? ST_WAIT : ST_DATA;
        end else begin
          s_nxt.cnt = s_r.cnt + 32'h1;
        end
      end
      ST_DATA: begin
        if (s_r.cnt == bit_cyc - 32'h1) begin
          s_nxt.cnt = '0;
          s_nxt.shreg = ch;
          s_nxt.bit_idx = s_r.bit_idx + 3'h1;
          if (s_r.bit_idx == 3'(DATA_BITS - 1)) begin
            s_nxt.st = ST_STOP;
          end
        end else begin
          s_nxt.cnt = s_r.cnt + 32'h1;
        end
      end
      ST_STOP: begin
        if (s_r.cnt == bit_cyc - 32'h1) begin
          s_nxt.cnt = '0;
          s_nxt.st = ST_WAIT;
          s_nxt.ms = '0;
          s_nxt.ms_cnt = '0;
          if (!s_r.dec) begin
            s_nxt.res.value = {8'h00, s_r.shreg};
            s_nxt.res.timed_out = 1'b0;
            s_nxt.res.done = 1'b1;
            s_nxt.st = ST_IDLE;
          end else if (is_digit(s_r.shreg)) begin
            s_nxt.seen_digit = 1'b1;
            s_nxt.acc = 16'(s_r.acc * TEN + {8'h00, s_r.shreg - ASCII_ZERO});
          end else if (s_r.seen_digit) begin
            s_nxt.res.value = s_r.acc;
            s_nxt.res.timed_out = 1'b0;
            s_nxt.res.done = 1'b1;
            s_nxt.st = ST_IDLE;
          end
        end else begin
          s_nxt.cnt = s_r.cnt + 32'h1;
        end
      end
      default: s_nxt.st = ST_IDLE;
    endcase
    // busy kept in a flop so the output is registered
    s_nxt.busy = (s_nxt.st != ST_IDLE);
  end

  // ------------------------------------------------------------
  // state register
  // ------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      s_r <= '0;
      s_r.st <= ST_IDLE;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign pin_oe_o = s_r.oe;
  assign busy_o = s_r.busy;
  assign result_o = s_r.res;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking @(posedge clk_i); endclocking
  default disable iff (srst_i);

  sequence start_seen;
    s_r.st == ST_WAIT && !line;
  endsequence

  start_to_sample_a: assert property (start_seen |=> s_r.st == ST_START)
    else $error("start edge not taken");
  oe_released_a: assert property (s_r.st != ST_IDLE |-> s_r.oe == '0)
    else $error("pin not input while receiving");
  no_tmo_off_a: assert property (!cfg_i.timeout_en && s_r.st == ST_WAIT && line
      |=> !s_r.res.timed_out || $stable(s_r.res.timed_out))
    else $error("timeout while disabled");
  tmo_done_a: assert property ($rose(s_r.res.timed_out) |-> s_r.res.done)
    else $error("timeout without completion");
  tmo_bound_a: assert property (s_r.res.done && s_r.res.timed_out
      |-> $past(s_r.ms) >= cfg_i.timeout_ms)
    else $error("timeout too early");
  raw_store_a: assert property (s_r.res.done && !s_r.res.timed_out && !s_r.dec
      |-> s_r.res.value[15:8] == 8'h00)
    else $error("raw value not a byte");
  dec_finish_a: assert property (s_r.res.done && !s_r.res.timed_out && s_r.dec
      |-> $past(s_r.seen_digit))
    else $error("decimal done without digit");
  idle_after_a: assert property (s_r.res.done |-> s_r.st == ST_IDLE)
    else $error("item not closed");
  bits_count_a: assert property (s_r.st == ST_DATA ##1 s_r.st == ST_STOP
      |-> s_r.bit_idx == 3'h0)
    else $error("wrong data bit count");
  done_not_busy_a: assert property (s_r.res.done |-> !busy_o)
    else $error("busy still high at completion");
  tmo_from_wait_a: assert property ($rose(s_r.res.timed_out)
      |-> $past(s_r.st) == ST_WAIT)
    else $error("timeout outside start wait");
  raw_value_a: assert property (s_r.res.done && !s_r.res.timed_out && !s_r.dec
      |-> s_r.res.value[7:0] == $past(s_r.shreg))
    else $error("raw byte altered");
endmodule

// file: verification/serial_tx_model.sv
// serial transmitter model standing on the far side of the receive pin
`timescale 1ns/1ps
module serial_tx_model #(
  parameter int unsigned BIT_CYC = 10
) (
  input wire logic clk_i,
  input wire logic inv_i,
  output wire logic pin_o
);
  logic tx_bit = 1'b1;
  logic [9:0] frame;
  // line level idles high before polarity
  assign pin_o = tx_bit ^ inv_i;
  task automatic send(input logic [7:0] b);
    frame = {1'b1, b, 1'b0};
    for (int i = 0; i < 11; i++) begin
      @(posedge clk_i) #1 tx_bit = (i < 10) ? frame[i] : 1'b1;
      repeat (BIT_CYC - 1) @(posedge clk_i);
    end
  endtask
endmodule

// file: verification/tb_top.sv
// testbench: receiver fed by the transmitter model
`timescale 1ns/1ps
module tb_top;
  import serial_rx_pkg::*;
  typedef struct {logic dec; logic inv; int n; logic [47:0] txt; logic [15:0] val;} row_s;
  logic clk_i, srst_i, item_start_i, item_dec_i, seen, tx_pin;
  rx_cfg_s cfg_i;
  logic [15:0] pin_oe_o;
  logic busy_o;
  rx_result_s result_o;
  int miscompares = 0;
  int checks_done = 0;
  row_s rows [6] = '{
    '{1'b0, 1'b1, 1, 48'h41, 16'h0041},
    '{1'b0, 1'b0, 1, 48'h31, 16'h0031},
    '{1'b0, 1'b1, 1, 48'ha5, 16'h00a5},
    '{1'b1, 1'b1, 3, 48'h31_3220, 16'h000c},
    '{1'b1, 1'b0, 4, 48'h4142_3778, 16'h0007},
    '{1'b1, 1'b1, 6, 48'h3730_3030_3020, 16'h1170}};
  serial_rx_dec #(.PINS(16), .CLK_FREQ(96000)) dut (.clk_i(clk_i), .srst_i(srst_i),
    .pins_i(tx_pin ? 16'h0020 : 16'hffdf), .cfg_i(cfg_i), .item_start_i(item_start_i),
    .item_dec_i(item_dec_i), .pin_oe_o(pin_oe_o), .busy_o(busy_o), .result_o(result_o));
  serial_tx_model #(.BIT_CYC(10)) tx (.clk_i(clk_i), .inv_i(cfg_i.invert), .pin_o(tx_pin));
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) if (result_o.done === 1'b1) seen = 1'b1;
  task automatic tally_and_finish;
    if (miscompares == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic check(input string name, input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic start_item(input logic dec, input logic inv);
    @(posedge clk_i) #1 cfg_i.invert = inv;
    repeat (20) @(posedge clk_i);
    #1 item_dec_i = dec;
    item_start_i = 1'b1;
    seen = 1'b0;
    @(posedge clk_i) #1 item_start_i = 1'b0;
    check("busy", {15'h0, busy_o}, 16'h0001);
    check("pin_oe", pin_oe_o, 16'h0000);
  endtask
  task automatic send_txt(input logic [47:0] txt, input int n);
    for (int k = n - 1; k >= 0; k--) tx.send(txt[8*k +: 8]);
  endtask
  task automatic wait_done;
    for (int i = 0; i < 400 && !seen; i++) @(posedge clk_i);
    check("done", {15'h0, seen}, 16'h0001);
  endtask
  initial begin
    #200000;
    miscompares++;
    tally_and_finish();
  end
  initial begin
    srst_i = 1'b1;
    item_start_i = 1'b0;
    item_dec_i = 1'b0;
    seen = 1'b0;
    cfg_i = '{BAUD_RST, TMO_RST, 1'b0, INV_RST, 4'h5};
    repeat (8) @(posedge clk_i);
    #1 check("reset", {result_o.value[13:0], busy_o, result_o.done}, 16'h0000);
    srst_i = 1'b0;
    foreach (rows[r]) begin
      start_item(rows[r].dec, rows[r].inv);
      send_txt(rows[r].txt, rows[r].n);
      wait_done();
      check("value", result_o.value, rows[r].val);
      check("timed_out", {15'h0, result_o.timed_out}, 16'h0000);
    end
    start_item(1'b1, 1'b1);
    send_txt(48'h35, 1);
    repeat (300) @(posedge clk_i);
    #1 check("pending", {14'h0, busy_o, seen}, 16'h0002);
    send_txt(48'h20, 1);
    wait_done();
    check("value", result_o.value, 16'h0005);
    @(posedge clk_i) #1 cfg_i.timeout_en = 1'b1;
    cfg_i.timeout_ms = 16'h0000;
    start_item(1'b0, 1'b1);
    wait_done();
    check("timed_out", {15'h0, result_o.timed_out}, 16'h0001);
    tally_and_finish();
  end
endmodule
